// File: src/emi_pkg.sv
// shared constants and carriers of the external memory interface
package emi_pkg;
  localparam logic [15:0] EMI_PAGE1_ADDR = 16'hC018;
  localparam logic [15:0] EMI_PAGE2_ADDR = 16'hC01A;
  localparam logic [15:0] EMI_CTRL_ADDR = 16'hC03A;
  localparam logic [15:0] EMI_STAT_ADDR = 16'hC03C;
  localparam int EMI_CTRL_WS_LSB = 0;
  localparam int EMI_CTRL_RAM_MERGE = 3;
  localparam int EMI_CTRL_ROM_MERGE = 4;
  localparam int EMI_CTRL_BUS16 = 5;
  localparam int EMI_CTRL_UPPER_EN = 6;
  localparam int EMI_STAT_BUSY = 0;
  localparam int EMI_STAT_BOOT = 1;
  localparam int EMI_STAT_SIG = 2;
  localparam logic [15:0] EMI_CTRL_RST = 16'h0007;
  localparam logic [15:0] EMI_PAGE_RST = 16'h0000;
  localparam logic [15:0] EMI_WIN_LO = 16'h8000;
  localparam logic [15:0] EMI_WIN_HI = 16'hBFFF;
  localparam logic [15:0] EMI_RAM_LO = 16'h4000;
  localparam logic [15:0] EMI_RAM_HI = 16'h7FFF;
  localparam logic [15:0] EMI_ROM_LO = 16'hC100;
  localparam logic [15:0] EMI_ROM_HI = 16'hDFFF;
  localparam logic [15:0] EMI_HOLE_LO = 16'hC000;
  localparam logic [15:0] EMI_HOLE_HI = 16'hC0FF;
  localparam logic [15:0] EMI_BOOT_SIG = 16'hC3B6;
  localparam logic [15:0] EMI_BOOT_SIG_ADDR = 16'hC100;
  localparam int EMI_CLK_NS = 10;
  localparam int EMI_WAIT_NS = 21;
  localparam int EMI_WAIT_CYC = (EMI_WAIT_NS + EMI_CLK_NS - 1) / EMI_CLK_NS;
  localparam int EMI_SETTLE_CYC = 2;
  localparam int EMI_BOOT_MS = 3;
  localparam int EMI_BOOT_CYC = EMI_BOOT_MS * 1000000 / EMI_CLK_NS;
  localparam logic [3:0] EMI_UPPER_IDLE = 4'hF;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emi_req_s;

  typedef struct packed {
    logic done;
    logic ext;
    logic hole;
    logic [15:0] rdata;
  } emi_rsp_s;

  typedef struct packed {
    logic [18:1] addr_hi;
    logic low_byte_enable_n;
    logic high_byte_enable_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic paged_window_select_n;
    logic ext_ram_select_n;
    logic ext_rom_select_n;
    logic [15:0] dout;
    logic doe;
  } emi_pin_s;

  localparam emi_pin_s EMI_PIN_IDLE = '{addr_hi: 18'h3C000, low_byte_enable_n: 1'b1,
    high_byte_enable_n: 1'b1, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
    paged_window_select_n: 1'b1, ext_ram_select_n: 1'b1, ext_rom_select_n: 1'b1,
    dout: 16'h0000, doe: 1'b0};
endpackage : emi_pkg

// File: src/emi_ctrl.sv
// external sram/rom interface: decode, paging, wait states, byte lanes
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - every external access strobes at least one wait
// - wait count programmable to seven, 30 ns (three 10 ns clocks) each
// - cpu sees flat 0x0000-0xFFFF, code or data
// - page one drives upper bits 0x8000-0x9FFF
// - page two drives upper bits 0xA000-0xBFFF
// - both page windows always active
// - window select: upper pins come from page
// - window select active 0x8000-0xBFFF always
// - ram select range widens with ram merge
// - rom select range widens, skips 0xC000-0xC0FF
// - merge bits live in control register
// - no code fetch from 0xC000-0xC0FF
// - dma never targets external memory
// - A18-A15 high until upper enable set
// - bus active during 3 ms boot
// - boot rom holds 0xC3B6 at 0xC100
// - eight and sixteen bit memories supported
// - sixteen bit mode pages 256K words
// - eight bit mode pages 512K bytes
module emi_ctrl #(
  parameter int BOOT_CYCLES = emi_pkg::EMI_BOOT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire emi_pkg::emi_req_s req,
  output logic req_ready,
  output emi_pkg::emi_rsp_s rsp,
  output emi_pkg::emi_pin_s pins,
  input wire logic [15:0] data_in,
  output logic boot_active
);
  import emi_pkg::*;

  typedef enum logic [2:0] {IDLE, STROBE, SETTLE, GAP, DONE} emi_fsm_e;

  typedef struct packed {
    emi_fsm_e st;
    logic [4:0] cnt;
    logic ph;
    logic write;
    logic [1:0] be;
    logic [15:0] caddr;
    logic [15:0] wdata;
    logic [15:0] page1;
    logic [15:0] page2;
    logic [15:0] ctrl;
    logic [15:0] rrd;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] d3;
    logic [19:0] boot_cnt;
    logic boot;
    logic sig_seen;
    logic [5:0] len;
    emi_rsp_s rsp;
    emi_pin_s pin;
  } emi_state_s;

  emi_state_s s;
  emi_state_s next;

  // bit 2 window, bit 1 ram, bit 0 rom
  function automatic logic [2:0] emi_decode(input logic [15:0] a, input logic ram_m,
                                            input logic rom_m);
    logic win;
    logic ram;
    logic rom;
    win = (a >= EMI_WIN_LO) && (a <= EMI_WIN_HI);
    ram = (a >= EMI_RAM_LO) && (a <= (ram_m ? EMI_WIN_HI : EMI_RAM_HI));
    rom = (a >= (rom_m ? EMI_WIN_LO : EMI_ROM_LO)) && (a <= EMI_ROM_HI) &&
          !((a >= EMI_HOLE_LO) && (a <= EMI_HOLE_HI));
    emi_decode = {win, ram, rom};
  endfunction : emi_decode

  // byte address on the pins; pages widen the window to 19 bits
  function automatic logic [18:0] emi_ext_addr(input logic [15:0] a, input logic [15:0] p1,
                                               input logic [15:0] p2);
    logic [15:0] pg;
    pg = a[13] ? p2 : p1;
    if ((a >= EMI_WIN_LO) && (a <= EMI_WIN_HI)) begin
      emi_ext_addr = {pg[5:0], a[12:0]};
    end else begin
      emi_ext_addr = {3'b000, a};
    end
  endfunction : emi_ext_addr

  function automatic logic [4:0] emi_wait_load(input logic [15:0] c);
    logic [2:0] ws;
    ws = c[EMI_CTRL_WS_LSB +: 3];
    if (ws == 3'h0) begin
      ws = 3'h1;
    end
    emi_wait_load = 5'(EMI_WAIT_CYC * int'(ws) - 1);
  endfunction : emi_wait_load

  logic bus8;
  logic [2:0] dec;
  logic hole;
  logic [18:0] ext;
  assign bus8 = !s.ctrl[EMI_CTRL_BUS16];
  assign dec = emi_decode(req.addr, s.ctrl[EMI_CTRL_RAM_MERGE], s.ctrl[EMI_CTRL_ROM_MERGE]);
  assign hole = req.fetch && (req.addr >= EMI_HOLE_LO) && (req.addr <= EMI_HOLE_HI);

  always_comb begin
    next = s;
    next.rsp.done = 1'b0;
    next.rrd = 16'h0000;
    // data pins are asynchronous to clk
    next.d1 = data_in;
    next.d2 = s.d1;
    next.d3 = s.d2;
    next.len = (!s.pin.write_strobe_n || !s.pin.read_strobe_n) ? s.len + 6'h01 : 6'h00;

    if (s.boot) begin
      next.boot_cnt = s.boot_cnt + 20'h00001;
      if (s.boot_cnt >= 20'(BOOT_CYCLES - 1)) begin
        next.boot = 1'b0;
      end
    end

    if (reg_wr) begin
      unique case (reg_addr)
        EMI_PAGE1_ADDR: next.page1 = reg_wdata;
        EMI_PAGE2_ADDR: next.page2 = reg_wdata;
        EMI_CTRL_ADDR: next.ctrl = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        EMI_PAGE1_ADDR: next.rrd = s.page1;
        EMI_PAGE2_ADDR: next.rrd = s.page2;
        EMI_CTRL_ADDR: next.rrd = s.ctrl;
        EMI_STAT_ADDR: begin
          next.rrd[EMI_STAT_BUSY] = s.st != IDLE;
          next.rrd[EMI_STAT_BOOT] = s.boot;
          next.rrd[EMI_STAT_SIG] = s.sig_seen;
        end
        default: next.rrd = 16'h0000;
      endcase
    end

    unique case (s.st)
      IDLE: begin
        if (req.valid) begin
          next.caddr = req.addr;
          next.write = req.write;
          next.be = req.be;
          next.wdata = req.wdata;
          next.rsp = '0;
          if (hole) begin
            next.rsp.done = 1'b1;
            next.rsp.hole = 1'b1;
          end else if (dec == 3'b000) begin
            next.rsp.done = 1'b1;
          end else begin
            next.rsp.ext = 1'b1;
            next.ph = bus8 && req.write && !req.be[0];
            next.pin.paged_window_select_n = !dec[2];
            next.pin.ext_ram_select_n = !dec[1];
            next.pin.ext_rom_select_n = !dec[0];
            next.cnt = emi_wait_load(s.ctrl);
            next.st = STROBE;
          end
        end
      end
      STROBE: begin
        if (s.cnt != 5'h00) begin
          next.cnt = s.cnt - 5'h01;
        end else if (!s.write) begin
          next.cnt = 5'(EMI_SETTLE_CYC);
          next.st = SETTLE;
        end else begin
          next.st = (bus8 && !s.ph && s.be[1]) ? GAP : DONE;
        end
      end
      SETTLE: begin
        // strobe stays low until the synchronised data is stable
        if (s.cnt != 5'h00) begin
          next.cnt = s.cnt - 5'h01;
        // upper data lines float on an 8-bit part, so only the low byte must settle
        end else if (bus8 ? (s.d2[7:0] == s.d3[7:0]) : (s.d2 == s.d3)) begin
          if (!bus8) begin
            next.rsp.rdata = s.d3;
          end else if (!s.ph) begin
            next.rsp.rdata[7:0] = s.d3[7:0];
          end else begin
            next.rsp.rdata[15:8] = s.d3[7:0];
          end
          next.st = (bus8 && !s.ph) ? GAP : DONE;
        end
      end
      GAP: begin
        next.ph = 1'b1;
        next.cnt = emi_wait_load(s.ctrl);
        next.st = STROBE;
      end
      DONE: begin
        next.pin.paged_window_select_n = 1'b1;
        next.pin.ext_ram_select_n = 1'b1;
        next.pin.ext_rom_select_n = 1'b1;
        next.rsp.done = 1'b1;
        if (!s.write && (s.caddr == EMI_BOOT_SIG_ADDR) && (s.rsp.rdata == EMI_BOOT_SIG)) begin
          next.sig_seen = 1'b1;
        end
        next.st = IDLE;
      end
    endcase

    // strobes and data drive follow the state being entered
    next.pin.write_strobe_n = !((next.st == STROBE || next.st == SETTLE) && next.write);
    next.pin.read_strobe_n = !((next.st == STROBE || next.st == SETTLE) && !next.write);
    next.pin.doe = (next.st == STROBE) && next.write;
    ext = emi_ext_addr(next.caddr, s.page1, s.page2);
    if (next.st == STROBE && s.st != STROBE) begin
      next.pin.addr_hi = ext[18:1];
      if (bus8) begin
        next.pin.low_byte_enable_n = next.ph;
        next.pin.high_byte_enable_n = 1'b1;
        next.pin.dout = {8'h00, next.ph ? next.wdata[15:8] : next.wdata[7:0]};
      end else begin
        next.pin.low_byte_enable_n = next.write && !next.be[0];
        next.pin.high_byte_enable_n = next.write && !next.be[1];
        next.pin.dout = next.wdata;
      end
    end
    if (!next.ctrl[EMI_CTRL_UPPER_EN]) begin
      next.pin.addr_hi[18:15] = EMI_UPPER_IDLE;
    end

    if (!rstn) begin
      next = '0;
      next.st = IDLE;
      next.ctrl = EMI_CTRL_RST;
      next.page1 = EMI_PAGE_RST;
      next.page2 = EMI_PAGE_RST;
      next.boot = 1'b1;
      next.pin = EMI_PIN_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s <= next;
  end

  assign req_ready = s.st == IDLE;
  assign rsp = s.rsp;
  assign pins = s.pin;
  assign reg_rdata = s.rrd;
  assign boot_active = s.boot;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic stb_n;
  logic [2:0] ws_eff;
  logic [2:0] cdec;
  assign stb_n = s.pin.write_strobe_n && s.pin.read_strobe_n;
  assign ws_eff = (s.ctrl[2:0] == 3'h0) ? 3'h1 : s.ctrl[2:0];
  assign cdec = emi_decode(s.caddr, s.ctrl[EMI_CTRL_RAM_MERGE], s.ctrl[EMI_CTRL_ROM_MERGE]);

  chk_min_wait: assert property ($fell(stb_n) |-> !stb_n [*3])
    else $error("strobe shorter than one wait state");

  chk_write_len: assert property ($rose(s.pin.write_strobe_n) && $stable(s.ctrl) |->
    s.len == 6'(EMI_WAIT_CYC * int'(ws_eff)))
    else $error("write strobe length does not match wait setting");

  chk_win_sel: assert property (s.pin.doe || !s.pin.read_strobe_n |->
    s.pin.paged_window_select_n == !cdec[2])
    else $error("window select wrong for access address");

  chk_page_pins: assert property (!s.pin.paged_window_select_n && !stb_n &&
    s.ctrl[EMI_CTRL_UPPER_EN] |-> s.pin.addr_hi[18:13] ==
    (s.caddr[13] ? s.page2[5:0] : s.page1[5:0]))
    else $error("upper pins not taken from page register");

  chk_ram_sel: assert property (!stb_n |-> s.pin.ext_ram_select_n ==
    !((s.caddr >= EMI_RAM_LO) &&
      (s.caddr <= (s.ctrl[EMI_CTRL_RAM_MERGE] ? EMI_WIN_HI : EMI_RAM_HI))))
    else $error("ram select wrong");

  chk_rom_hole: assert property (!stb_n |-> s.pin.ext_rom_select_n ||
    !((s.caddr >= EMI_HOLE_LO) && (s.caddr <= EMI_HOLE_HI)))
    else $error("rom select inside reserved area");

  chk_fetch_hole: assert property (req_ready && req.valid && hole |=>
    s.rsp.done && s.rsp.hole && stb_n ##1 stb_n)
    else $error("code fetch from hole reached the bus");

  chk_upper_high: assert property (!s.ctrl[EMI_CTRL_UPPER_EN] |->
    s.pin.addr_hi[18:15] == EMI_UPPER_IDLE)
    else $error("upper address pins not held high");

  chk_reg_read: assert property (reg_rd && reg_addr == EMI_CTRL_ADDR && !reg_wr |=>
    reg_rdata == $past(s.ctrl))
    else $error("control register read back wrong");

  chk_byte_lane: assert property (!s.pin.write_strobe_n && !bus8 |->
    s.pin.low_byte_enable_n == !s.be[0] && s.pin.high_byte_enable_n == !s.be[1])
    else $error("byte enables do not follow write lanes");

  chk_boot_end: assert property (s.boot_cnt == 20'(BOOT_CYCLES - 1) && s.boot |=>
    !boot_active)
    else $error("boot window did not end");

  cov_read8: cover property ($rose(s.pin.read_strobe_n) && bus8 && s.ph);
  cov_rom_merge: cover property (!s.pin.ext_rom_select_n && s.ctrl[EMI_CTRL_ROM_MERGE] &&
    !s.pin.paged_window_select_n);
  cov_hole: cover property (s.rsp.done && s.rsp.hole);
  cov_write16: cover property ($rose(s.pin.write_strobe_n) && !bus8);
endmodule : emi_ctrl

`default_nettype wire

// File: tb/emi_mem_model.sv
// behavioural external sram answering the memory pins
`timescale 1ns/100ps
`default_nettype none
module emi_mem_model (
  input wire logic clk,
  input wire logic bus16,
  input wire logic [3:0] lag,
  input wire emi_pkg::emi_pin_s pins,
  output logic [15:0] data_in
);
  import emi_pkg::*;
  logic [7:0] mem [int];
  int k;
  int n;
  logic sel;
  logic [15:0] bus = 16'hA55A;
  assign data_in = bus;
  assign sel = !(pins.paged_window_select_n & pins.ext_ram_select_n & pins.ext_rom_select_n);
  assign k = int'(bus16 ? {pins.addr_hi, 1'b0} : {pins.addr_hi, pins.low_byte_enable_n});
  function automatic logic [7:0] rd(input int a);
    rd = mem.exists(a) ? mem[a] : 8'h5A;
  endfunction : rd
  // strobes without a chip select are ignored
  always @(posedge clk) begin
    n <= (sel && !pins.read_strobe_n) ? n + 1 : 0;
    if (sel && !pins.write_strobe_n) begin
      if (!bus16 || !pins.low_byte_enable_n) mem[k] = pins.dout[7:0];
      if (bus16 && !pins.high_byte_enable_n) mem[k + 1] = pins.dout[15:8];
    end
    // slow part: bus keeps toggling until lag cycles into the strobe
    if (sel && !pins.read_strobe_n && n >= lag)
      bus <= {bus16 ? rd(k + 1) : ~bus[15:8], rd(k)};
    else
      bus <= ~bus;
  end
endmodule : emi_mem_model
`default_nettype wire

// File: tb/tb_external_memory_interface.sv
// self-checking bench for the external memory interface
`timescale 1ns/100ps
`default_nettype none
module tb_external_memory_interface;
  import emi_pkg::*;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, boot_active, req_ready, bus16 = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, data_in, rdat, a, d, pg;
  logic [3:0] lag = 0;
  logic [2:0] sel_seen;
  logic [18:1] a_seen;
  emi_req_s req = '0;
  emi_rsp_s rsp;
  emi_pin_s pins;
  int fail_count = 0, n_checks = 0, lo = 0, i, m;
  logic [15:0] at [11] = '{16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000,
    16'hBFFF, 16'hC0FE, 16'hC100, 16'hDFFE, 16'hE000};
  int wst [3] = '{0, 1, 7};
  always #5 clk = ~clk;
  emi_ctrl #(.BOOT_CYCLES(50)) emi_ctrl_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins), .data_in(data_in),
    .boot_active(boot_active));
  emi_mem_model emi_mem_model_i (.clk(clk), .bus16(bus16), .lag(lag), .pins(pins),
    .data_in(data_in));
  // clear on each taken request, then latch selects and address at the first strobe cycle
  always @(posedge clk) if (req.valid && req_ready) begin
    lo <= 0;
    sel_seen <= 3'h0;
  end else if (!(pins.write_strobe_n & pins.read_strobe_n)) begin
    if (lo == 0) begin
      sel_seen <= ~{pins.paged_window_select_n, pins.ext_ram_select_n, pins.ext_rom_select_n};
      a_seen <= pins.addr_hi;
    end
    lo <= lo + 1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic reg_write(input logic [15:0] ad, input logic [15:0] wd);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] ad, output logic [15:0] rd);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read
  // settings changed only between accesses, from the idle bus
  task automatic set_ctl(input int ws, input bit rm, input bit om, input bit b);
    bus16 = b;
    reg_write(EMI_CTRL_ADDR, 16'(ws) << EMI_CTRL_WS_LSB | 16'(rm) << EMI_CTRL_RAM_MERGE
      | 16'(om) << EMI_CTRL_ROM_MERGE | 16'(b) << EMI_CTRL_BUS16
      | 16'h0001 << EMI_CTRL_UPPER_EN);
  endtask : set_ctl
  task automatic cpu(input logic w, input logic f, input logic [1:0] be,
      input logic [15:0] ad, input logic [15:0] wd);
    int t;
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, fetch: f, be: be, addr: ad, wdata: wd};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req <= '0;
    for (t = 0; t < 300 && rsp.done !== 1'b1; t++) @(negedge clk);
    check("done", t < 300, 1);
    rdat = rsp.rdata;
  endtask : cpu
  function automatic logic [2:0] esel(input int x, input bit rm, input bit om);
    esel[2] = x >= 16'h8000 && x <= 16'hBFFF;
    esel[1] = x >= 16'h4000 && x <= (rm ? 16'hBFFF : 16'h7FFF);
    esel[0] = x >= (om ? 16'h8000 : 16'hC100) && x <= 16'hDFFF && !(x >= 16'hC000 && x < 16'hC100);
  endfunction : esel
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h0E86));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1 check("upper", pins.addr_hi[18:15], 4'hF);
    check("boot", boot_active, 1);
    reg_read(EMI_CTRL_ADDR, d); check("ctrl", d, EMI_CTRL_RST);
    reg_read(EMI_PAGE1_ADDR, d); check("pg1", d, EMI_PAGE_RST);
    reg_read(16'hC002, d); check("unmap", d, 0);
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      set_ctl(1, m[0], m[1], 1);
      foreach (at[j]) begin
        cpu(0, 0, 2'h3, at[j], 0);
        check("sel", sel_seen, esel(at[j], m[0], m[1]));
        check("ext", rsp.ext, |esel(at[j], m[0], m[1]));
      end
    end
    $display("test decode done");
    set_ctl(2, 0, 0, 0);
    for (i = 0; i < 2; i++) begin
      pg = 16'($urandom) & 16'h003F;
      reg_write(i ? EMI_PAGE2_ADDR : EMI_PAGE1_ADDR, pg);
      a = 16'h8000 | 16'(i) << 13 | (16'($urandom) & 16'h1FFE);
      d = 16'($urandom);
      cpu(1, 0, 2'h3, a, d);
      check("page", a_seen[18:13], pg[5:0]);
      check("offs", a_seen[12:1], a[12:1]);
      check("wcyc8", lo, 2 * EMI_WAIT_CYC * 2);
      lag = 4'(i * 4);
      cpu(0, 0, 2'h3, a, 0);
      check("rd8", rdat, d);
    end
    lag = 0;
    $display("test paging done");
    a = 16'h4000 | (16'($urandom) & 16'h3FFE);
    foreach (wst[j]) begin
      set_ctl(wst[j], 0, 0, 1);
      d = 16'($urandom);
      cpu(1, 0, 2'h3, a, d);
      check("wcyc16", lo, EMI_WAIT_CYC * (wst[j] ? wst[j] : 1));
    end
    cpu(1, 0, 2'h1, a, ~d);
    cpu(0, 0, 2'h3, a, 0);
    check("lane", rdat, {d[15:8], ~d[7:0]});
    $display("test waits done");
    cpu(0, 1, 2'h3, 16'hC080, 0);
    check("hole", rsp.hole, 1);
    check("nobus", lo, 0);
    cpu(0, 1, 2'h3, a, 0);
    check("fetch", {rsp.hole, rsp.ext, rdat}, {2'b01, d[15:8], ~d[7:0]});
    cpu(1, 0, 2'h3, EMI_BOOT_SIG_ADDR, EMI_BOOT_SIG);
    cpu(0, 0, 2'h3, EMI_BOOT_SIG_ADDR, 0);
    reg_read(EMI_STAT_ADDR, d);
    check("sig", d[EMI_STAT_SIG], 1);
    check("booted", boot_active, 0);
    $display("test fetch done");
    print_verdict();
  end
endmodule : tb_external_memory_interface
`default_nettype wire
